/* pkg/ccsp_pkg.sv */
package ccsp_pkg;

   // register offsets (byte addresses)
   localparam logic [7:0] CCSP_OFF_DATA    = 8'h00;
   localparam logic [7:0] CCSP_OFF_SCRATCH = 8'h04;
   localparam logic [7:0] CCSP_OFF_CTRL    = 8'h08;
   localparam logic [7:0] CCSP_OFF_SEED    = 8'h10;
   localparam logic [7:0] CCSP_OFF_GEN     = 8'h14;

   // reset values
   localparam logic [31:0] CCSP_CTRL_RESET    = 32'h00000000;
   localparam logic [31:0] CCSP_SEED_RESET    = 32'hffffffff;
   localparam logic [31:0] CCSP_GEN_RESET     = 32'h04c11db7;
   localparam logic [31:0] CCSP_RESULT_RESET  = 32'hffffffff;
   localparam logic [7:0]  CCSP_SCRATCH_RESET = 8'h00;

   // control field positions
   localparam int CCSP_LOAD_BIT    = 0;
   localparam int CCSP_SIZE_LSB    = 3;
   localparam int CCSP_INFLIP_LSB  = 5;
   localparam int CCSP_OUTFLIP_BIT = 7;

   // width masks per size select
   localparam logic [31:0] CCSP_MASK32 = 32'hffffffff;
   localparam logic [31:0] CCSP_MASK16 = 32'h0000ffff;
   localparam logic [31:0] CCSP_MASK8  = 32'h000000ff;
   localparam logic [31:0] CCSP_MASK7  = 32'h0000007f;

   // calculation cycles per input word
   localparam logic [2:0] CCSP_STEPS32 = 3'h4;
   localparam logic [2:0] CCSP_STEPS16 = 3'h2;
   localparam logic [2:0] CCSP_STEPS8  = 3'h1;

   typedef enum logic [1:0] {
      CCSP_SIZE32 = 2'b00,
      CCSP_SIZE16 = 2'b01,
      CCSP_SIZE8  = 2'b10,
      CCSP_SIZE7  = 2'b11
   } ccsp_size_t;

   typedef enum logic [1:0] {
      CCSP_FLIP_NONE = 2'b00,
      CCSP_FLIP_BYTE = 2'b01,
      CCSP_FLIP_HALF = 2'b10,
      CCSP_FLIP_WORD = 2'b11
   } ccsp_flip_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } ccsp_req_t;

   typedef struct packed {
      logic        outputBitFlip;
      ccsp_flip_t  inputBitFlipMode;
      ccsp_size_t  polySizeSel;
      logic [31:0] seedValue;
      logic [31:0] generatorValue;
      logic [31:0] result;
      logic [7:0]  scratch;
      logic        bufValid;
      logic        busy;
      logic [31:0] bufData;
      logic [31:0] shiftData;
      logic [2:0]  stepsLeft;
      logic [31:0] rdData;
   } ccsp_state_t;

endpackage

/* rtl/ccsp_top.sv */
//Contract
// - load bit copies seed into result, self-clears
// - load never touches the scratch byte
// - bit 7 reverses result bit order on read
// - bits 6:5 pick input reversal group size
// - bits 4:3 pick polynomial width 32/16/8/7
// - seed resets all ones, feeds reloads
// - generator resets to default, used masked
// - results accumulate from previous result
// - 4/2/1 cycles per word, buffered input
// - seed write also reloads the result
// - bits above selected width are ignored after input reversal
`timescale 1ns/10ps
module ccsp_top
   import ccsp_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire ccsp_req_t   req,
   output logic [31:0]      rdData,
   output logic             inputFull,
   output logic             calcBusy
);

   logic [1:0]  rstSync_reg;
   logic        rstLocal_n;
   ccsp_state_t state_reg;
   ccsp_state_t state_next;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rstSync_reg <= 2'b00;
      end else begin
         rstSync_reg <= {rstSync_reg[0], 1'b1};
      end
   end
   assign rstLocal_n = rstSync_reg[1];

   function automatic logic [31:0] widthMask(input ccsp_size_t ps);
      logic [31:0] m;
      unique case (ps)
         CCSP_SIZE32: m = CCSP_MASK32;
         CCSP_SIZE16: m = CCSP_MASK16;
         CCSP_SIZE8:  m = CCSP_MASK8;
         CCSP_SIZE7:  m = CCSP_MASK7;
      endcase
      return m;
   endfunction

   function automatic logic [31:0] flipIn(input logic [31:0] d,
                                          input ccsp_flip_t mode);
      logic [31:0] r;
      r = d;
      for (int i = 0; i < 32; i++) begin
         unique case (mode)
            CCSP_FLIP_NONE: r[i] = d[i];
            CCSP_FLIP_BYTE: r[i] = d[(i & 24) + 7 - (i & 7)];
            CCSP_FLIP_HALF: r[i] = d[(i & 16) + 15 - (i & 15)];
            CCSP_FLIP_WORD: r[i] = d[31 - i];
         endcase
      end
      return r;
   endfunction

   // result shown in the selected width only, reversed within it when outputBitFlip is set
   function automatic logic [31:0] shownResult(input ccsp_state_t s);
      logic [31:0] r;
      r = s.result & widthMask(s.polySizeSel);
      if (s.outputBitFlip) begin
         for (int i = 0; i < 32; i++) begin
            r[i] = s.result[31 - i];
         end
         unique case (s.polySizeSel)
            CCSP_SIZE32: r = r;
            CCSP_SIZE16: r = r >> 16;
            CCSP_SIZE8:  r = r >> 24;
            CCSP_SIZE7:  r = r >> 25;
         endcase
      end
      return r;
   endfunction

   // one byte (seven bits for the 7-bit size), msb first
   function automatic logic [31:0] crcByte(input logic [31:0] c,
                                           input logic [7:0] d,
                                           input ccsp_size_t ps,
                                           input logic [31:0] generator_value);
      logic [31:0] m;
      logic [31:0] x;
      logic        fb;
      m  = widthMask(ps);
      x  = c & m;
      fb = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (!(ps == CCSP_SIZE7 && i == 7)) begin
            unique case (ps)
               CCSP_SIZE32: fb = x[31] ^ d[7 - i];
               CCSP_SIZE16: fb = x[15] ^ d[7 - i];
               CCSP_SIZE8:  fb = x[7] ^ d[7 - i];
               CCSP_SIZE7:  fb = x[6] ^ d[7 - i];
            endcase
            x = (x << 1) & m;
            if (fb) begin
               x = x ^ (generator_value & m);
            end
         end
      end
      return x;
   endfunction

   always_comb begin
      logic [31:0] aligned;
      logic [2:0]  steps;
      logic        reload;
      state_next = state_reg;
      aligned    = 32'h00000000;
      steps      = CCSP_STEPS8;
      reload     = 1'b0;

      unique case (state_reg.polySizeSel)
         CCSP_SIZE32: steps = CCSP_STEPS32;
         CCSP_SIZE16: steps = CCSP_STEPS16;
         CCSP_SIZE8:  steps = CCSP_STEPS8;
         CCSP_SIZE7:  steps = CCSP_STEPS8;
      endcase

      // engine: one byte per cycle from the running result
      if (state_reg.stepsLeft != 3'h0) begin
         state_next.result = crcByte(state_reg.result,
                                     state_reg.shiftData[31:24],
                                     state_reg.polySizeSel,
                                     state_reg.generatorValue);
         state_next.shiftData = state_reg.shiftData << 8;
         state_next.stepsLeft = state_reg.stepsLeft - 3'h1;
      end else if (state_reg.bufValid) begin
         aligned = flipIn(state_reg.bufData,
                          state_reg.inputBitFlipMode)
                   & widthMask(state_reg.polySizeSel);
         unique case (state_reg.polySizeSel)
            CCSP_SIZE32: state_next.shiftData = aligned;
            CCSP_SIZE16: state_next.shiftData = aligned << 16;
            CCSP_SIZE8:  state_next.shiftData = aligned << 24;
            CCSP_SIZE7:  state_next.shiftData = aligned << 25;
         endcase
         state_next.stepsLeft = steps;
         state_next.bufValid  = 1'b0;
      end

      if (req.rd) begin
         unique case (req.addr)
            CCSP_OFF_DATA:    state_next.rdData = shownResult(state_reg);
            CCSP_OFF_SCRATCH: state_next.rdData = {24'h000000,
                                                   state_reg.scratch};
            // load bit is never stored, so it reads zero
            CCSP_OFF_CTRL:    state_next.rdData = {
                                 24'h000000,
                                 state_reg.outputBitFlip,
                                 state_reg.inputBitFlipMode,
                                 state_reg.polySizeSel,
                                 3'b000};
            CCSP_OFF_SEED:    state_next.rdData = state_reg.seedValue;
            CCSP_OFF_GEN:     state_next.rdData = state_reg.generatorValue;
            default:          state_next.rdData = 32'h00000000;
         endcase
      end

      if (req.wr) begin
         unique case (req.addr)
            // a write while the buffer is full and the engine busy replaces the waiting word
            CCSP_OFF_DATA: begin
               state_next.bufData  = req.wdata;
               state_next.bufValid = 1'b1;
            end
            CCSP_OFF_SCRATCH: state_next.scratch = req.wdata[7:0];
            CCSP_OFF_CTRL: begin
               // reserved bits dropped; software keeps them zero
               state_next.outputBitFlip    =
                  req.wdata[CCSP_OUTFLIP_BIT];
               state_next.inputBitFlipMode = ccsp_flip_t'(
                  req.wdata[CCSP_INFLIP_LSB +: 2]);
               state_next.polySizeSel      = ccsp_size_t'(
                  req.wdata[CCSP_SIZE_LSB +: 2]);
               reload = req.wdata[CCSP_LOAD_BIT];
            end
            // full-word writes assumed, no byte lanes exist
            CCSP_OFF_SEED: begin
               state_next.seedValue = req.wdata;
               reload = 1'b1;
            end
            CCSP_OFF_GEN: state_next.generatorValue = req.wdata;
            default: ;
         endcase
      end

      // reload aborts any running or waiting word; scratch untouched
      if (reload) begin
         state_next.result    = state_next.seedValue;
         state_next.stepsLeft = 3'h0;
         state_next.bufValid  = 1'b0;
      end

      // busy kept in a flop so the output pin is registered
      state_next.busy = (state_next.stepsLeft != 3'h0);
   end

   always_ff @(posedge clock or negedge rstLocal_n) begin
      if (!rstLocal_n) begin
         state_reg.outputBitFlip    <= CCSP_CTRL_RESET[CCSP_OUTFLIP_BIT];
         state_reg.inputBitFlipMode <= CCSP_FLIP_NONE;
         state_reg.polySizeSel      <= CCSP_SIZE32;
         state_reg.seedValue        <= CCSP_SEED_RESET;
         state_reg.generatorValue   <= CCSP_GEN_RESET;
         state_reg.result           <= CCSP_RESULT_RESET;
         state_reg.scratch          <= CCSP_SCRATCH_RESET;
         state_reg.bufValid         <= 1'b0;
         state_reg.bufData          <= 32'h00000000;
         state_reg.shiftData        <= 32'h00000000;
         state_reg.stepsLeft        <= 3'h0;
         state_reg.busy             <= 1'b0;
         state_reg.rdData           <= 32'h00000000;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rdData    = state_reg.rdData;
   assign inputFull = state_reg.bufValid;
   assign calcBusy  = state_reg.busy;

endmodule

/* sim/ccsp_top_sva.sv */
`timescale 1ns/10ps
module ccsp_top_sva
   import ccsp_pkg::*;
(
   input wire logic        clock,
   input wire logic        rst_n,
   input wire ccsp_req_t   req,
   input wire logic [31:0] rdData,
   input wire logic        inputFull,
   input wire logic        calcBusy
);
   logic [4:0]  ctlReg;
   logic [31:0] seedReg;
   logic [7:0]  scratchReg;
   logic        wrCtl;
   logic        wrData;
   logic        rdPlain;
   assign wrCtl  = req.wr && req.addr == CCSP_OFF_CTRL;
   assign wrData = req.wr && req.addr == CCSP_OFF_DATA;
   // unflipped 32-bit view only, so the raw seed is the expected read
   assign rdPlain = req.rd && !req.wr && req.addr == CCSP_OFF_DATA
                    && ctlReg == 5'h00;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctlReg     <= 5'h00;
         seedReg    <= CCSP_SEED_RESET;
         scratchReg <= CCSP_SCRATCH_RESET;
      end else if (req.wr) begin
         if (req.addr == CCSP_OFF_CTRL) ctlReg <= req.wdata[7:3];
         if (req.addr == CCSP_OFF_SEED) seedReg <= req.wdata;
         if (req.addr == CCSP_OFF_SCRATCH) scratchReg <= req.wdata[7:0];
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_gen_readback: assert property (
      (req.wr && req.addr == CCSP_OFF_GEN)
      ##1 (req.rd && !req.wr && req.addr == CCSP_OFF_GEN)
      |=> rdData == $past(req.wdata, 2))
      else $error("generator read differs");
   a_seed_reload: assert property (
      (req.wr && req.addr == CCSP_OFF_SEED) ##1 rdPlain
      |=> rdData == $past(seedReg)) else $error("seed not loaded");
   a_load_reload: assert property (
      (wrCtl && req.wdata[0]) ##1 rdPlain
      |=> rdData == $past(seedReg)) else $error("load bit did not reload");
   a_busy_word: assert property (
      $rose(calcBusy) && ctlReg[1:0] == 2'b00
      |-> calcBusy [*4] ##1 (!calcBusy || $past(inputFull)))
      else $error("word calculation length wrong");
   a_busy_byte: assert property ($rose(calcBusy) && ctlReg[1]
      |=> !calcBusy || $past(inputFull))
      else $error("byte calc length wrong");
   a_take_word: assert property (wrData && !inputFull && !calcBusy
      |=> inputFull ##1 (!inputFull && calcBusy))
      else $error("word not taken");
   a_scratch_keep: assert property (
      req.rd && req.addr == CCSP_OFF_SCRATCH
      |=> rdData == {24'h000000, $past(scratchReg)})
      else $error("scratch lost");
   a_ctrl_fields: assert property (
      req.rd && req.addr == CCSP_OFF_CTRL
      |=> rdData == {24'h000000, $past(ctlReg), 3'h0})
      else $error("control read back wrong");
   c_calc: cover property ($rose(calcBusy));
   c_load: cover property (wrCtl && req.wdata[0]);
   c_buffered: cover property (inputFull && calcBusy);
endmodule
bind ccsp_top ccsp_top_sva i_ccsp_top_sva (.clock(clock), .rst_n(rst_n),
   .req(req), .rdData(rdData), .inputFull(inputFull), .calcBusy(calcBusy));

/* sim/ccsp_top_bench.sv */
`timescale 1ns/10ps
module ccsp_top_bench
   import ccsp_pkg::*;
;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   ccsp_req_t   req = '0;
   logic [31:0] rdData;
   logic        inputFull;
   logic        calcBusy;
   logic [31:0] lf = 32'h6895;
   logic [31:0] seed, generator_value, d1, d2, sc, m;
   logic [4:0]  ctl = 5'h00;
   int          w;
   int          n_mismatch = 0;
   int          cmp_count = 0;
   ccsp_top i_ccsp_top (.clock(clock), .rst_n(rst_n), .req(req),
      .rdData(rdData), .inputFull(inputFull), .calcBusy(calcBusy));
   always #12.5 clock = ~clock;
   assign w = ctl[1] ? (ctl[0] ? 7 : 8) : (ctl[0] ? 16 : 32);
   assign m = w == 32 ? 32'hffffffff : (32'h1 << w) - 32'h1;
   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic acc(input logic wr, input logic rd, input logic [7:0] a,
                      input logic [31:0] d);
      @(negedge clock);
      req <= '{wr, rd, a, d};
   endtask
   task automatic idle();
      acc(1'b0, 1'b0, 8'h00, 32'h0);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      acc(1'b0, 1'b1, a, 32'h0);
      idle();
      cmp_count++;
      if (rdData !== e) begin
         $display("unexpected at %0t: got %h expected %h", $time, rdData, e);
         n_mismatch++;
      end
   endtask
   // bounded, so a stuck busy flag ends the run instead of hanging it
   task automatic waitq(input logic busyToo);
      int k;
      for (k = 0; k < 40 && (inputFull !== 1'b0 ||
           (busyToo && calcBusy !== 1'b0)); k++) @(negedge clock);
      if (k == 40) begin
         n_mismatch++;
         summarize();
      end
   endtask
   task automatic rnd(output logic [31:0] v);
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      v = lf;
   endtask
   function automatic logic [31:0] rv(logic [31:0] x, int g, int n);
      logic [31:0] y;
      y = x;
      for (int i = 0; i < n; i++) y[(i / g) * g + g - 1 - i % g] = x[i];
      return y;
   endfunction
   function automatic logic [31:0] step(logic [31:0] r, logic [31:0] d);
      logic [31:0] x;
      logic        fb;
      x = (ctl[3:2] == 2'b00 ? d : rv(d, 4 << ctl[3:2], 32)) & m;
      r = r & m;
      for (int i = w - 1; i >= 0; i--) begin
         fb = r[w - 1] ^ x[i];
         r = ((r << 1) & m) ^ (fb ? generator_value & m : 32'h0);
      end
      return r;
   endfunction
   function automatic logic [31:0] outv(logic [31:0] r);
      return ctl[4] ? rv(r & m, w, w) : r & m;
   endfunction
   initial begin
      repeat (6) @(negedge clock);
      rst_n = 1'b1;
      repeat (3) @(posedge clock);
      rdc(CCSP_OFF_CTRL, CCSP_CTRL_RESET);
      rdc(CCSP_OFF_SEED, CCSP_SEED_RESET);
      rdc(CCSP_OFF_GEN, CCSP_GEN_RESET);
      rdc(CCSP_OFF_DATA, CCSP_RESULT_RESET);
      rdc(8'h0c, 32'h0);
      $display("reset values test done");
      ctl = 5'h10;
      acc(1'b1, 1'b0, CCSP_OFF_CTRL, {24'h0, ctl, 3'h0});
      acc(1'b1, 1'b0, CCSP_OFF_SEED, 32'h3344ccdd);
      rdc(CCSP_OFF_DATA, 32'hbb3322cc);
      $display("output flip test done");
      for (int i = 0; i < 12; i++) begin
         rnd(seed);
         rnd(generator_value);
         rnd(d1);
         rnd(d2);
         rnd(sc);
         // first pass keeps the plain view so the reload checks engage
         ctl = i == 0 ? 5'h00 : sc[12:8];
         acc(1'b1, 1'b0, CCSP_OFF_CTRL, {24'h0, ctl, 3'h0});
         acc(1'b1, 1'b0, CCSP_OFF_GEN, generator_value);
         rdc(CCSP_OFF_GEN, generator_value);
         acc(1'b1, 1'b0, CCSP_OFF_SEED, seed);
         rdc(CCSP_OFF_DATA, outv(seed));
         acc(1'b1, 1'b0, CCSP_OFF_SCRATCH, sc);
         acc(1'b1, 1'b0, CCSP_OFF_DATA, d1);
         idle();
         waitq(1'b0);
         acc(1'b1, 1'b0, CCSP_OFF_DATA, d2);
         idle();
         waitq(1'b1);
         d2 = outv(step(step(seed, d1), d2));
         rdc(CCSP_OFF_DATA, d2);
         acc(1'b1, 1'b0, CCSP_OFF_CTRL, {24'h0, ctl, 3'h1});
         rdc(CCSP_OFF_DATA, outv(seed));
         rdc(CCSP_OFF_CTRL, {24'h0, ctl, 3'h0});
         rdc(CCSP_OFF_SCRATCH, {24'h0, sc[7:0]});
         $display("random test %0d done", i);
      end
      summarize();
   end
endmodule
